// ===== shared/azs_defs.vh
// Constants for the accumulator zone/sign conditioning block
`ifndef AZS_DEFS_VH
`define AZS_DEFS_VH

// ****************************************************************
// Character layout
// ****************************************************************
`define AZS_CHAR_W      6
`define AZS_ZONE_X_BIT  5
`define AZS_ZONE_O_BIT  4
`define AZS_DIGIT_HI    3
`define AZS_DIGIT_LO    0
`define AZS_DIGIT_W     4
`define AZS_ZONE_NONE   2'h0

// ****************************************************************
// Accumulator store
// ****************************************************************
`define AZS_ACC_LEN     10
`define AZS_ACC_IDX_W   4
`define AZS_ACC_LAST    4'h9
`define AZS_SIGN_POS    4'h0
`define AZS_DIGIT_RST   4'h0
`define AZS_SIGN_RST    1'b0

// ****************************************************************
// Instruction register
// ****************************************************************
`define AZS_IR_LEN      10
`define AZS_IR_W        60
`define AZS_IR_IDX_W    4
`define AZS_IR_ALL      10'h3FF
// Positions (index 0 = first character) that keep their zones
`define AZS_IR_KEEP     10'h109
`define AZS_IR_RST      60'h0

// ****************************************************************
// Readout sequencer states
// ****************************************************************
`define AZS_ST_IDLE     1'b0
`define AZS_ST_READ     1'b1

`endif

// ===== core/azs_core.v
// Accumulator zone/sign conditioning and instruction register
// ****************************************************************
// Contract
// RULE1: Incoming accumulator characters lose both zone bits except in the sign-control position.
// RULE2: The first, low-order character entering an accumulator is the sign-control character.
// RULE3: The accumulator goes negative only when that character carries the X zone bit.
// RULE4: A negative accumulator is read out with the X bit added to its lowest-order digit.
// RULE5: Data landing one position left loses its X bit, which misses the sign position.
// RULE6: A read-out-and-reset operation delivers the contents and clears the accumulator.
// RULE7: A load can clear the accumulator in the same operation that brings the data in.
// RULE8: Each instruction is copied into the instruction register and executed from there.
// RULE9: The instruction register holds ten characters, one per fixed instruction position.
// RULE10: Positions 2, 3, 5, 6, 7, 8 and 10 of the instruction register keep only the digit.
// RULE11: Positions 1, 4 and 9 of the instruction register keep the full zoned character.
// RULE12: An indicator bank shows every instruction register character while executing.
// RULE13: The accumulator sign is a separate state bit, set on entry and used on readout.
// ****************************************************************
`include "azs_defs.vh"

module azs_core (
  // Clock and reset
  input  wire                         i_clk,
  input  wire                         i_rst,
  // Accumulator entry stream (low-order character first)
  input  wire                         i_in_valid,
  input  wire                         i_in_first,
  input  wire                         i_in_shift,
  input  wire                         i_in_clear,
  input  wire [`AZS_CHAR_W-1:0]       i_in_char,
  // Accumulator readout request
  input  wire                         i_rd_start,
  input  wire                         i_rd_reset,
  // Accumulator readout stream toward the core buffer
  output reg                          o_rd_valid,
  output reg                          o_rd_last,
  output reg  [`AZS_CHAR_W-1:0]       o_rd_char,
  output reg                          o_acc_neg,
  output reg                          o_rd_busy,
  // Instruction register load
  input  wire                         i_ir_clear,
  input  wire                         i_ir_wr,
  input  wire [`AZS_IR_IDX_W-1:0]     i_ir_pos,
  input  wire [`AZS_CHAR_W-1:0]       i_ir_char,
  input  wire                         i_executing,
  // Instruction register outputs
  output reg                          o_exec_start,
  output reg  [`AZS_IR_W-1:0]         o_ir_word,
  output reg  [`AZS_IR_W-1:0]         o_lamp_word
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Keep only the numeric digit of a character
  function [`AZS_CHAR_W-1:0] strip_zone;
    input [`AZS_CHAR_W-1:0] c;
    begin
      strip_zone = {`AZS_ZONE_NONE, c[`AZS_DIGIT_HI:`AZS_DIGIT_LO]};
    end
  endfunction

  // ****************************************************************
  // Accumulator store
  // ****************************************************************
  reg [`AZS_DIGIT_W-1:0]   acc_q [0:`AZS_ACC_LEN-1];
  reg                      sign_q;
  reg [`AZS_ACC_IDX_W-1:0] wr_idx_q;
  reg [`AZS_ACC_IDX_W-1:0] rd_idx_q;
  reg                      st_q;
  reg                      rd_rst_q;
  integer                  k;

  // Readout sequencer states
  localparam [0:0] ST_IDLE = `AZS_ST_IDLE;
  localparam [0:0] ST_READ = `AZS_ST_READ;

  // Target position of the incoming character
  wire [`AZS_ACC_IDX_W-1:0] in_pos;
  wire                      in_sign_pos;
  wire                      end_read;

  // A shifted entry lands one place left of the sign-control position
  assign in_pos      = i_in_first ? (i_in_shift ? (`AZS_SIGN_POS + 4'h1) : `AZS_SIGN_POS)
                                  : wr_idx_q;
  assign in_sign_pos = i_in_first & ~i_in_shift;                     // [RULE2] [RULE5]
  assign end_read    = (st_q == ST_READ) && (rd_idx_q == `AZS_ACC_LAST);

  // Entry, sign capture, readout clear
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (k = 0; k < `AZS_ACC_LEN; k = k + 1) begin
        acc_q[k] <= `AZS_DIGIT_RST;
      end
      sign_q   <= `AZS_SIGN_RST;
      wr_idx_q <= `AZS_SIGN_POS;
    end else begin
      if (i_in_valid) begin
        if (i_in_first && i_in_clear) begin
          for (k = 0; k < `AZS_ACC_LEN; k = k + 1) begin
            acc_q[k] <= `AZS_DIGIT_RST;                            // [RULE7]
          end
        end
        // Vacated low position of a shifted entry reads as zero
        if (i_in_first && i_in_shift) begin
          acc_q[`AZS_SIGN_POS] <= `AZS_DIGIT_RST;
        end
        // Only the digit is stored; zones never reach the store
        acc_q[in_pos] <= i_in_char[`AZS_DIGIT_HI:`AZS_DIGIT_LO];     // [RULE1]
        if (i_in_first) begin
          // Blank or unzoned sign character leaves it positive
          sign_q <= in_sign_pos & i_in_char[`AZS_ZONE_X_BIT];        // [RULE3] [RULE5] [RULE13]
        end
        wr_idx_q <= (in_pos == `AZS_ACC_LAST) ? `AZS_ACC_LAST : in_pos + 4'h1;
      end else if ((st_q == ST_READ) && rd_rst_q) begin
        // Read-out-and-reset clears each digit as it leaves
        acc_q[rd_idx_q] <= `AZS_DIGIT_RST;                           // [RULE6]
        if (end_read) begin
          sign_q <= `AZS_SIGN_RST;                                   // [RULE6]
        end
      end
    end
  end

  // ****************************************************************
  // Readout sequencer
  // ****************************************************************
  // One character per cycle, low-order first; entry has priority
  // over the reset clear, so callers must not overlap the two.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q       <= ST_IDLE;
      rd_idx_q   <= `AZS_SIGN_POS;
      rd_rst_q   <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_last  <= 1'b0;
      o_rd_char  <= {`AZS_CHAR_W{1'b0}};
      o_rd_busy  <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      o_rd_last  <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (i_rd_start) begin
            st_q      <= ST_READ;
            rd_idx_q  <= `AZS_SIGN_POS;
            rd_rst_q  <= i_rd_reset;
            o_rd_busy <= 1'b1;
          end
        end
        ST_READ: begin
          o_rd_valid <= 1'b1;
          o_rd_last  <= end_read;
          // Negative sign marks the lowest-order digit with an X bit
          o_rd_char  <= {(rd_idx_q == `AZS_SIGN_POS) & sign_q, 1'b0,
                         acc_q[rd_idx_q]};                           // [RULE4] [RULE13]
          if (end_read) begin
            st_q      <= ST_IDLE;
            o_rd_busy <= 1'b0;
          end else begin
            rd_idx_q <= rd_idx_q + 4'h1;
          end
        end
        default: begin
          st_q      <= ST_IDLE;
          o_rd_busy <= 1'b0;
        end
      endcase
    end
  end

  // Sign shown to sequencing logic
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_acc_neg <= `AZS_SIGN_RST;
    end else begin
      o_acc_neg <= sign_q;                                           // [RULE13]
    end
  end

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  reg [`AZS_IR_LEN-1:0] ir_fill_q;
  reg [`AZS_CHAR_W-1:0] ir_val;
  reg [`AZS_IR_LEN-1:0] ir_fill_d;
  reg [`AZS_IR_LEN-1:0] ir_keep;

  // Zone handling depends only on the fixed position
  always @* begin
    // Full-width shift so no keep bit is lost before the test
    ir_keep   = `AZS_IR_KEEP >> i_ir_pos;
    ir_val    = ir_keep[0] ? i_ir_char : strip_zone(i_ir_char);     // [RULE10] [RULE11]
    ir_fill_d = ir_fill_q;
    if (i_ir_wr && (i_ir_pos < `AZS_IR_LEN)) begin
      ir_fill_d = ir_fill_q | (10'h001 << i_ir_pos);
    end
  end

  // Ten dedicated character slots; execution starts once all are in
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ir_word    <= `AZS_IR_RST;
      ir_fill_q    <= {`AZS_IR_LEN{1'b0}};
      o_exec_start <= 1'b0;
    end else begin
      o_exec_start <= 1'b0;
      if (i_ir_clear) begin
        ir_fill_q <= {`AZS_IR_LEN{1'b0}};
      end else begin
        if (i_ir_wr && (i_ir_pos < `AZS_IR_LEN)) begin
          o_ir_word[i_ir_pos*`AZS_CHAR_W +: `AZS_CHAR_W] <= ir_val;  // [RULE9]
        end
        ir_fill_q <= ir_fill_d;
        // Fires once, on the write that completes the copy
        if ((ir_fill_q != `AZS_IR_ALL) && (ir_fill_d == `AZS_IR_ALL)) begin
          o_exec_start <= 1'b1;                                      // [RULE8]
        end
      end
    end
  end

  // Indicator bank mirrors the register only while executing
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lamp_word <= `AZS_IR_RST;
    end else begin
      o_lamp_word <= i_executing ? o_ir_word : `AZS_IR_RST;          // [RULE12]
    end
  end

endmodule // azs_core

// ===== tb/azs_chk_monitor.sv
// Checker for the zone/sign block, bound to its ports
`include "azs_defs.vh"
module azs_chk_monitor (
  // Clock, reset and entry
  input logic        i_clk, i_rst, i_in_valid, i_in_first, i_in_shift, i_in_clear,
  input logic [5:0]  i_in_char,
  // Readout
  input logic        i_rd_start, i_rd_reset, o_rd_valid, o_rd_last, o_acc_neg, o_rd_busy,
  input logic [5:0]  o_rd_char,
  // Instruction register
  input logic        i_ir_clear, i_ir_wr, i_executing, o_exec_start,
  input logic [3:0]  i_ir_pos,
  input logic [5:0]  i_ir_char,
  input logic [59:0] o_ir_word, o_lamp_word
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] KEEP = `AZS_IR_KEEP;
  // Zone bits of the stripping positions; they must never show
  function automatic logic [59:0] zmask();
    logic [59:0] m;
    m = '0;
    for (int p = 0; p < 10; p++) if (!KEEP[p]) m[6*p+4 +: 2] = 2'h3;
    return m;
  endfunction
  localparam logic [59:0] ZM = zmask();
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ****************************************************************
  // Properties
  // ****************************************************************
  a_rd_start_lat: assert property (i_rd_start && !o_rd_busy
    |=> o_rd_busy ##1 o_rd_valid) else $error("readout latency wrong");
  a_rd_ten_chars: assert property ($rose(o_rd_valid) |-> (o_rd_valid && !o_rd_last)[*8]
    ##1 o_rd_valid && !o_rd_last ##1 o_rd_valid && o_rd_last ##1 !o_rd_valid)
    else $error("readout frame wrong");
  a_rd_sign_mark: assert property ($rose(o_rd_valid)
    |-> o_rd_char[5] == o_acc_neg) else $error("sign mark wrong");
  a_rd_zone_drop: assert property (o_rd_valid && !$rose(o_rd_valid) |-> !o_rd_char[5])
    else $error("upper char zoned");
  a_rd_no_ozone: assert property (o_rd_valid |-> !o_rd_char[4])
    else $error("0 zone on readout");
  a_sign_from_entry: assert property (i_in_valid && i_in_first && !i_in_shift
    && !o_rd_busy |-> ##2 o_acc_neg == $past(i_in_char[5], 2))
    else $error("sign not from first char");
  a_shift_positive: assert property (i_in_valid && i_in_first && i_in_shift
    |-> ##2 !o_acc_neg) else $error("shifted entry negative");
  a_ir_zone_strip: assert property ((o_ir_word & ZM) == 60'h0)
    else $error("zone kept in ir");
  a_ir_zone_keep: assert property (i_ir_wr && !i_ir_clear && i_ir_pos < 4'hA
    && KEEP[i_ir_pos] |=> o_ir_word[6*$past(i_ir_pos) +: 6] == $past(i_ir_char))
    else $error("zone lost in ir");
  a_lamp_follow: assert property (i_executing |=> o_lamp_word == $past(o_ir_word))
    else $error("lamps wrong");
  a_exec_pulse: assert property (o_exec_start |=> !o_exec_start)
    else $error("exec start not a pulse");
  // Main scenarios
  c_neg_read: cover property ($rose(o_rd_valid) && o_rd_char[5]);
  c_rd_reset: cover property (i_rd_start && i_rd_reset && !o_rd_busy);
  c_exec: cover property (o_exec_start);
endmodule // azs_chk_monitor
bind azs_core azs_chk_monitor azs_chk_monitor_inst (.i_clk, .i_rst, .i_in_valid, .i_in_first,
  .i_in_shift, .i_in_clear, .i_in_char, .i_rd_start, .i_rd_reset, .o_rd_valid, .o_rd_last,
  .o_acc_neg, .o_rd_busy, .o_rd_char, .i_ir_clear, .i_ir_wr, .i_executing, .o_exec_start,
  .i_ir_pos, .i_ir_char, .o_ir_word, .o_lamp_word);

// ===== tb/azs_buf_model.sv
// Core buffer model: collects the accumulator readout stream
module azs_buf_model (
  // Readout stream
  input logic       i_clk, i_rd_valid, i_rd_last,
  input logic [5:0] i_rd_char
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cells[$];  // Low order first
  int         frames;
  // No ready line exists, so the buffer takes every valid cycle
  always @(posedge i_clk) begin
    if (i_rd_valid) cells.push_back(i_rd_char);
    if (i_rd_valid && i_rd_last) frames++;
  end
endmodule // azs_buf_model

// ===== tb/tb.sv
// Self-checking bench for the zone/sign block
`include "azs_defs.vh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h seen %0h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] KEEP = `AZS_IR_KEEP;
  logic i_clk, i_rst, i_in_valid, i_in_first, i_in_shift, i_in_clear, i_rd_start, i_rd_reset;
  logic i_ir_clear, i_ir_wr, i_executing, o_rd_valid, o_rd_last, o_acc_neg, o_rd_busy;
  logic o_exec_start;
  logic [5:0] i_in_char, i_ir_char, o_rd_char;
  logic [3:0] i_ir_pos;
  logic [59:0] o_ir_word, o_lamp_word, ir_exp;
  int bad_count, n_compared, acc[10], neg;
  azs_core azs_core_inst (.i_clk, .i_rst, .i_in_valid, .i_in_first, .i_in_shift, .i_in_clear,
    .i_in_char, .i_rd_start, .i_rd_reset, .o_rd_valid, .o_rd_last, .o_rd_char, .o_acc_neg,
    .o_rd_busy, .i_ir_clear, .i_ir_wr, .i_ir_pos, .i_ir_char, .i_executing, .o_exec_start,
    .o_ir_word, .o_lamp_word);
  azs_buf_model azs_buf_model_inst (.i_clk, .i_rd_valid(o_rd_valid), .i_rd_last(o_rd_last),
    .i_rd_char(o_rd_char));
  initial begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic tick();
    @(posedge i_clk);
    #10;
  endtask
  // Entry with zoned digits; the model mirrors the store
  task automatic enter(int n, bit shf, bit clr, bit xfirst);
    logic [5:0] c;
    for (int k = 0; k < n; k++) begin
      c = {2'($urandom), 4'($urandom % 10)};
      if (k == 0) c[5] = xfirst;
      {i_in_valid, i_in_first, i_in_shift, i_in_clear, i_in_char} = {1'b1, k == 0, shf, clr, c};
      if (k == 0 && clr) acc = '{default: 0};
      if (k == 0 && shf) acc[0] = 0;
      acc[(k + shf > 9) ? 9 : k + shf] = c[3:0];
      if (k == 0) neg = shf ? 0 : c[5];
      tick();
    end
    i_in_valid = 0;
    tick();
    `CHK("sign", neg, o_acc_neg)
  endtask
  // Readout, with a start while busy that must be refused
  task automatic readout(bit rst);
    int f;
    f = azs_buf_model_inst.frames;
    azs_buf_model_inst.cells.delete();
    {i_rd_start, i_rd_reset} = {1'b1, rst};
    tick();
    i_rd_start = 0;
    repeat (4) tick();
    i_rd_start = 1;
    tick();
    i_rd_start = 0;
    for (int w = 0; w < 20 && azs_buf_model_inst.frames == f; w++) tick();
    repeat (4) tick();
    `CHK("count", 10, azs_buf_model_inst.cells.size())
    for (int k = 0; k < 10; k++)
      `CHK("char", acc[k] | 32 * (k == 0 && neg), azs_buf_model_inst.cells[k])
    if (rst) acc = '{default: 0};
    if (rst) neg = 0;
    `CHK("sign", neg, o_acc_neg)
  endtask
  // Instruction load in scrambled order, after an ignored write
  task automatic ir_load();
    logic [5:0] c;
    i_ir_clear = 1;
    tick();
    {i_ir_clear, i_ir_wr, i_ir_pos, i_ir_char} = {2'b01, 4'(10 + $urandom % 6), 6'h3F};
    tick();
    for (int k = 0; k < 10; k++) begin
      c = 6'($urandom);
      i_ir_pos = 4'((k * 3) % 10);
      i_ir_char = c;
      ir_exp[6 * i_ir_pos +: 6] = KEEP[i_ir_pos] ? c : c & 6'h0F;
      tick();
    end
    i_ir_wr = 0;
    `CHK("start", 1'b1, o_exec_start)
    `CHK("word", ir_exp, o_ir_word)
    tick();
    `CHK("lamps", ir_exp, o_lamp_word)
    i_executing = 0;
    repeat (2) tick();
    `CHK("dark", 60'h0, o_lamp_word)
    i_executing = 1;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog at several times the expected run
  initial begin
    #(100 * 2000);
    bad_count++;
    end_sim();
  end
  initial begin
    {i_in_valid, i_in_first, i_in_shift, i_in_clear, i_in_char, i_rd_start, i_rd_reset} = '0;
    {i_ir_clear, i_ir_wr, i_ir_pos, i_ir_char} = '0;
    i_executing = 1;
    i_rst = 1;
    acc = '{default: 0};
    void'($urandom(32'h6a97));
    repeat (20) @(posedge i_clk);
    #10 i_rst = 0;
    for (int r = 0; r < 2; r++) begin
      enter(10, 0, 1, 1);
      readout(0);
      enter(10, 0, 0, 0);
      readout(0);
      $display("test signed entry done");
      enter(9, 1, 0, 1);
      readout(0);
      $display("test shifted entry done");
      enter(3, 0, 1, 1);
      readout(1);
      readout(0);
      $display("test clear and reset done");
      ir_load();
      $display("test instruction register done");
    end
    end_sim();
  end
endmodule // tb
